// [cci_pkg.sv]
/*
 cpu control instruction decoder constants: opcode classes, standby codes,
 timing counts. assumes a fetch unit that presents pre-decoded instruction classes.
*/
package cci_pkg;
    localparam int CLK_MHZ            = 20;
    localparam int IDLE_CLOCKS        = 2;
    localparam logic [7:0] STBY_STOP  = 8'h02;
    localparam logic [7:0] STBY_RST   = 8'h00;
    localparam logic [1:0] BANK_RST   = 2'h0;
    localparam logic       IE_RST     = 1'b0;
    localparam int BANK_LO_POS        = 0;
    localparam int BANK_HI_POS        = 1;
    localparam int EXT_FORMS          = 15;
    localparam int ADDR_W             = 16;
    typedef enum logic [4:0] {
        CCI_OP_NONE, CCI_OP_STBY, CCI_OP_BANK, CCI_OP_IDLE, CCI_OP_EI, CCI_OP_DI,
        CCI_OP_MULSGN, CCI_OP_LD_HLI, CCI_OP_ST_HLI, CCI_OP_LD_DE, CCI_OP_ST_DE,
        CCI_OP_LD_DEI, CCI_OP_ST_DEI, CCI_OP_LD_ABS, CCI_OP_ST_ABS, CCI_OP_XCH_HL,
        CCI_OP_XCH_DE, CCI_OP_XCH_IDX, CCI_OP_ALU_DE, CCI_OP_ALU_IDX, CCI_OP_CALL_RP
    } cci_op_t;
    typedef enum logic [3:0] {
        CCI_X_NONE, CCI_X_MULSGN, CCI_X_LD_HLI, CCI_X_ST_HLI, CCI_X_LD_DE,
        CCI_X_ST_DE, CCI_X_LD_DEI, CCI_X_ST_DEI, CCI_X_LD_ABS, CCI_X_ST_ABS,
        CCI_X_XCH_HL, CCI_X_XCH_DE, CCI_X_XCH_IDX, CCI_X_ALU_DE, CCI_X_ALU_IDX,
        CCI_X_CALL_RP
    } cci_ext_t;
endpackage : cci_pkg

// [cci_ext_map.sv]
/*
 maps a fetched op class to the extended form code handed to the datapath.
 assumes the op class is stable while op_valid is high.
*/
`timescale 1ns/1ps
module cci_ext_map (
    input  wire cci_pkg::cci_op_t  op,
    output cci_pkg::cci_ext_t      ext
);
    always_comb begin
        unique case (op)
            cci_pkg::CCI_OP_MULSGN:  ext = cci_pkg::CCI_X_MULSGN;
            cci_pkg::CCI_OP_LD_HLI:  ext = cci_pkg::CCI_X_LD_HLI;
            cci_pkg::CCI_OP_ST_HLI:  ext = cci_pkg::CCI_X_ST_HLI;
            cci_pkg::CCI_OP_LD_DE:   ext = cci_pkg::CCI_X_LD_DE;
            cci_pkg::CCI_OP_ST_DE:   ext = cci_pkg::CCI_X_ST_DE;
            cci_pkg::CCI_OP_LD_DEI:  ext = cci_pkg::CCI_X_LD_DEI;
            cci_pkg::CCI_OP_ST_DEI:  ext = cci_pkg::CCI_X_ST_DEI;
            cci_pkg::CCI_OP_LD_ABS:  ext = cci_pkg::CCI_X_LD_ABS;
            cci_pkg::CCI_OP_ST_ABS:  ext = cci_pkg::CCI_X_ST_ABS;
            cci_pkg::CCI_OP_XCH_HL:  ext = cci_pkg::CCI_X_XCH_HL;
            cci_pkg::CCI_OP_XCH_DE:  ext = cci_pkg::CCI_X_XCH_DE;
            cci_pkg::CCI_OP_XCH_IDX: ext = cci_pkg::CCI_X_XCH_IDX;
            cci_pkg::CCI_OP_ALU_DE:  ext = cci_pkg::CCI_X_ALU_DE;
            cci_pkg::CCI_OP_ALU_IDX: ext = cci_pkg::CCI_X_ALU_IDX;
            cci_pkg::CCI_OP_CALL_RP: ext = cci_pkg::CCI_X_CALL_RP;
            default:                 ext = cci_pkg::CCI_X_NONE;
        endcase
    end
endmodule : cci_ext_map

// [cci_ctrl.sv]
/*
 cpu control instruction executor: standby load, bank select, idle, irq enable
 and disable, and hand-off of the extended forms to the datapath.
 assumes fetch holds op/imm/addr until op_ready; one clock, synchronous reset.
*/
// Summary of operation
// - a dedicated op copies any 8-bit immediate into the standby control register, flags kept.
// - loading 02H into the standby control register raises the stop standby mode.
// - bank select writes its 2-bit operand to the bank bits for all later instructions.
// - the idle instruction takes exactly two clocks and changes nothing.
// - the enable instruction sets the global irq enable flag; each source keeps its own mask.
// - the disable instruction clears the flag; macro service requests still pass.
// - fifteen extended forms are recognised and handed to the datapath.
// - absolute operands of the extended moves carry a full 16-bit address.
`timescale 1ns/1ps
module cci_ctrl (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  op_valid,
    input  wire cci_pkg::cci_op_t      op,
    input  wire logic [7:0]            imm,
    input  wire logic [15:0]           abs_addr,
    input  wire logic                  irq_req,
    input  wire logic                  irq_src_enabled,
    input  wire logic                  macro_req,
    output logic                       op_ready,
    output logic [7:0]                 standby_control_reg,
    output logic                       stop_mode,
    output logic                       bank_select_high_bit,
    output logic                       bank_select_low_bit,
    output logic                       global_irq_enable_flag,
    output logic                       irq_accept,
    output logic                       macro_accept,
    output logic                       ext_valid,
    output cci_pkg::cci_ext_t          ext_form,
    output logic [15:0]                ext_addr,
    output logic                       flags_we
);
    typedef struct packed {
        logic [7:0]          stby;
        logic [1:0]          bank;
        logic                ie;
        logic                idle_busy;
        logic                ext_v;
        cci_pkg::cci_ext_t   ext_f;
        logic [15:0]         ext_a;
        logic                irq_acc;
        logic                mac_acc;
        logic                stop;
    } cci_state_t;

    cci_state_t        st;
    cci_state_t        next_st;
    cci_pkg::cci_ext_t ext_code;
    logic              take;
    logic              ext_take;

    cci_ext_map u_map (
        .op  (op),
        .ext (ext_code)
    );

    // idle holds fetch off for its first clock
    assign op_ready = !(op_valid && op == cci_pkg::CCI_OP_IDLE && !st.idle_busy);
    assign take     = op_valid && op_ready;
    assign ext_take = take && (ext_code != cci_pkg::CCI_X_NONE);

    always_comb begin
        next_st         = st;
        next_st.ext_v   = 1'b0;
        next_st.irq_acc = irq_req && irq_src_enabled && st.ie;
        next_st.mac_acc = macro_req;
        next_st.idle_busy = 1'b0;
        if (op_valid && op == cci_pkg::CCI_OP_IDLE && !st.idle_busy) begin
            next_st.idle_busy = 1'b1;
        end
        if (take) begin
            unique case (op)
                cci_pkg::CCI_OP_STBY: next_st.stby = imm;
                cci_pkg::CCI_OP_BANK: next_st.bank = imm[1:0];
                cci_pkg::CCI_OP_EI:   next_st.ie   = 1'b1;
                cci_pkg::CCI_OP_DI:   next_st.ie   = 1'b0;
                cci_pkg::CCI_OP_IDLE,
                cci_pkg::CCI_OP_NONE: ;
                default: begin
                    // the fifteen extended forms and undefined class codes land here; only the extended forms start the datapath
                    if (ext_code != cci_pkg::CCI_X_NONE) begin
                        next_st.ext_v = 1'b1;
                        next_st.ext_f = ext_code;
                        next_st.ext_a = abs_addr;
                    end
                end
            endcase
        end
        // registered so the mode pin is glitch free
        next_st.stop = (next_st.stby == cci_pkg::STBY_STOP);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st       <= '0;
            st.stby  <= cci_pkg::STBY_RST;
            st.bank  <= cci_pkg::BANK_RST;
            st.ie    <= cci_pkg::IE_RST;
            st.ext_f <= cci_pkg::CCI_X_NONE;
            st.stop  <= (cci_pkg::STBY_RST == cci_pkg::STBY_STOP);
        end else begin
            st <= next_st;
        end
    end

    assign standby_control_reg    = st.stby;
    assign stop_mode              = st.stop;
    assign bank_select_high_bit   = st.bank[cci_pkg::BANK_HI_POS];
    assign bank_select_low_bit    = st.bank[cci_pkg::BANK_LO_POS];
    assign global_irq_enable_flag = st.ie;
    assign irq_accept             = st.irq_acc;
    assign macro_accept           = st.mac_acc;
    assign ext_valid              = st.ext_v;
    assign ext_form               = st.ext_f;
    assign ext_addr               = st.ext_a;
    // none of the control ops touch the flags
    assign flags_we               = 1'b0;

    property p_stby_load;
        @(posedge mclk) disable iff (rst)
        (take && op == cci_pkg::CCI_OP_STBY) |=> (standby_control_reg == $past(imm));
    endproperty
    a_stby_load: assert property (p_stby_load) else $error("standby load wrong");

    property p_stop;
        @(posedge mclk) disable iff (rst)
        (take && op == cci_pkg::CCI_OP_STBY && imm == cci_pkg::STBY_STOP) |=> stop_mode;
    endproperty
    a_stop: assert property (p_stop) else $error("stop mode not entered");

    property p_bank;
        @(posedge mclk) disable iff (rst)
        (take && op == cci_pkg::CCI_OP_BANK) |=>
            ({bank_select_high_bit, bank_select_low_bit} == $past(imm[1:0]));
    endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");

    sequence s_idle_start;
        op_valid && op == cci_pkg::CCI_OP_IDLE && !st.idle_busy;
    endsequence
    property p_idle;
        @(posedge mclk) disable iff (rst)
        s_idle_start |-> !op_ready ##1 (op_ready && $stable(standby_control_reg)
            && $stable(global_irq_enable_flag));
    endproperty
    a_idle: assert property (p_idle) else $error("idle not two clocks");

    property p_ei;
        @(posedge mclk) disable iff (rst)
        (take && op == cci_pkg::CCI_OP_EI) |=> global_irq_enable_flag;
    endproperty
    a_ei: assert property (p_ei) else $error("enable failed");

    property p_di;
        @(posedge mclk) disable iff (rst)
        (take && op == cci_pkg::CCI_OP_DI) |=> !global_irq_enable_flag ##1 !irq_accept;
    endproperty
    a_di: assert property (p_di) else $error("disable failed");

    property p_macro;
        @(posedge mclk) disable iff (rst)
        macro_req |=> macro_accept;
    endproperty
    a_macro: assert property (p_macro) else $error("macro request lost");

    property p_ext;
        @(posedge mclk) disable iff (rst)
        (take && op == cci_pkg::CCI_OP_LD_ABS) |=>
            (ext_valid && ext_form == cci_pkg::CCI_X_LD_ABS && ext_addr == $past(abs_addr));
    endproperty
    a_ext: assert property (p_ext) else $error("extended form lost");

    property p_stby_hold;
        @(posedge mclk) disable iff (rst)
        !(take && op == cci_pkg::CCI_OP_STBY) |=> $stable(standby_control_reg);
    endproperty
    a_stby_hold: assert property (p_stby_hold) else $error("standby register drifted");

    property p_stop_exit;
        @(posedge mclk) disable iff (rst)
        (take && op == cci_pkg::CCI_OP_STBY && imm != cci_pkg::STBY_STOP) |=> !stop_mode;
    endproperty
    a_stop_exit: assert property (p_stop_exit) else $error("stop mode on wrong code");

    property p_bank_hold;
        @(posedge mclk) disable iff (rst)
        !(take && op == cci_pkg::CCI_OP_BANK) |=>
            $stable({bank_select_high_bit, bank_select_low_bit});
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank bits drifted");

    sequence s_idle_take;
        take && op == cci_pkg::CCI_OP_IDLE;
    endsequence
    sequence s_idle_quiet;
        $stable(standby_control_reg) && $stable(global_irq_enable_flag) && !ext_valid;
    endsequence
    property p_idle_quiet;
        @(posedge mclk) disable iff (rst)
        s_idle_take |=> s_idle_quiet;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle changed state");

    property p_ie_hold;
        @(posedge mclk) disable iff (rst)
        !(take && (op == cci_pkg::CCI_OP_EI || op == cci_pkg::CCI_OP_DI)) |=>
            $stable(global_irq_enable_flag);
    endproperty
    a_ie_hold: assert property (p_ie_hold) else $error("irq enable flag drifted");

    property p_irq_pass;
        @(posedge mclk) disable iff (rst)
        (irq_req && irq_src_enabled && global_irq_enable_flag) |=> irq_accept;
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("enabled request refused");

    property p_irq_mask;
        @(posedge mclk) disable iff (rst)
        !irq_src_enabled |=> !irq_accept;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked source accepted");

    property p_irq_block;
        @(posedge mclk) disable iff (rst)
        !global_irq_enable_flag |=> !irq_accept;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("request taken while disabled");

    property p_macro_quiet;
        @(posedge mclk) disable iff (rst)
        !macro_req |=> !macro_accept;
    endproperty
    a_macro_quiet: assert property (p_macro_quiet) else $error("macro accept unasked");

    property p_ext_start;
        @(posedge mclk) disable iff (rst)
        ext_take |=> (ext_valid && ext_form == $past(ext_code));
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("extended form not issued");

    property p_ext_quiet;
        @(posedge mclk) disable iff (rst)
        !ext_take |=> !ext_valid;
    endproperty
    a_ext_quiet: assert property (p_ext_quiet) else $error("spurious extended issue");

    property p_ext_addr;
        @(posedge mclk) disable iff (rst)
        ext_take |=> (ext_addr == $past(abs_addr));
    endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("extended address lost");

    property p_ext_addr_hold;
        @(posedge mclk) disable iff (rst)
        !ext_take |=> $stable(ext_addr);
    endproperty
    a_ext_addr_hold: assert property (p_ext_addr_hold) else $error("address drifted");
endmodule : cci_ctrl

// [cpu_control_instructions_tb_top.sv]
/*
 random plus corner-case bench for cci_ctrl.
 assumes ops are held until taken and outputs settle 1 ns after mclk rises.
*/
`timescale 1ns/1ps
module cpu_control_instructions_tb_top;
    logic mclk, rst, op_valid, irq_req, irq_src_enabled, macro_req;
    logic op_ready, stop_mode, bhi, blo, ie, irq_accept, macro_accept, ext_valid, flags_we;
    cci_pkg::cci_op_t  op;
    cci_pkg::cci_ext_t ext_form;
    logic [7:0]  imm, stby, e_stby, v;
    logic [15:0] abs_addr, ext_addr, a;
    logic [1:0]  e_bank;
    logic        e_ie;
    int          mismatches, n_tests;
    cci_ctrl dut (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op(op), .imm(imm),
        .abs_addr(abs_addr), .irq_req(irq_req), .irq_src_enabled(irq_src_enabled),
        .macro_req(macro_req), .op_ready(op_ready), .standby_control_reg(stby),
        .stop_mode(stop_mode), .bank_select_high_bit(bhi), .bank_select_low_bit(blo),
        .global_irq_enable_flag(ie), .irq_accept(irq_accept), .macro_accept(macro_accept),
        .ext_valid(ext_valid), .ext_form(ext_form), .ext_addr(ext_addr), .flags_we(flags_we));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        $display("checks=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    function automatic logic exp_stop(input logic [7:0] s);
        return s == cci_pkg::STBY_STOP;
    endfunction : exp_stop
    function automatic logic exp_irq(input logic [2:0] r, input logic en);
        return r[0] & r[1] & en;
    endfunction : exp_irq
    // state is compared after every op except the enable before the mid-test reset; nothing may drift
    task state_ok;
        chk(stby, e_stby);
        chk(stop_mode, exp_stop(e_stby));
        chk({bhi, blo}, e_bank);
        chk(ie, e_ie);
        chk(flags_we, 1'h0);
    endtask : state_ok
    task do_op(input cci_pkg::cci_op_t o, input logic [7:0] i, input logic [15:0] ad);
        @(posedge mclk);
        op_valid <= 1'b1;
        op <= o;
        imm <= i;
        abs_addr <= ad;
        #1;
        if (o == cci_pkg::CCI_OP_IDLE) begin
            chk(op_ready, 1'h0);
            @(posedge mclk);
            #1;
        end
        chk(op_ready, 1'h1);
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
    endtask : do_op
    initial begin
        #(50 * 4000);
        mismatches++;
        wrap_up;
    end
    initial begin
        {rst, op_valid, irq_req, irq_src_enabled, macro_req} = 5'h10;
        op = cci_pkg::CCI_OP_NONE;
        {imm, abs_addr, mismatches, n_tests} = '0;
        {e_stby, e_bank, e_ie} = '0;
        void'($urandom(61));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        state_ok;
        $display("test reset done");
        for (int k = 0; k < 24; k++) begin
            v = (k < 3) ? {6'h00, k[1:0]} : ((k == 3) ? 8'hFF : 8'($urandom));
            do_op(cci_pkg::CCI_OP_STBY, v, 16'h0000);
            e_stby = v;
            state_ok;
        end
        $display("test standby done");
        for (int k = 0; k < 8; k++) begin
            v = 8'($urandom);
            do_op(cci_pkg::CCI_OP_BANK, {v[7:2], k[1:0]}, 16'h0000);
            e_bank = k[1:0];
            state_ok;
        end
        $display("test bank done");
        do_op(cci_pkg::CCI_OP_IDLE, 8'h02, 16'hFFFF);
        state_ok;
        do_op(cci_pkg::CCI_OP_NONE, 8'h5A, 16'h0000);
        state_ok;
        $display("test idle done");
        for (int k = 0; k < 16; k++) begin
            do_op(k[3] ? cci_pkg::CCI_OP_DI : cci_pkg::CCI_OP_EI, 8'h00, 16'h0000);
            e_ie = !k[3];
            state_ok;
            @(posedge mclk);
            {macro_req, irq_src_enabled, irq_req} <= k[2:0];
            @(posedge mclk);
            #1;
            chk(irq_accept, exp_irq(k[2:0], e_ie));
            chk(macro_accept, k[2]);
        end
        $display("test irq done");
        for (int k = 6; k <= 20; k++) begin
            a = (k == 13) ? 16'hFFFF : ((k == 14) ? 16'h0000 : 16'($urandom));
            do_op(cci_pkg::cci_op_t'(k), 8'($urandom), a);
            chk(ext_valid, 1'h1);
            chk(ext_form, k - 5);
            if (k == 13 || k == 14) chk(ext_addr, a);
            state_ok;
            @(posedge mclk);
            #1;
            chk(ext_valid, 1'h0);
        end
        $display("test extended done");
        do_op(cci_pkg::CCI_OP_EI, 8'h00, 16'h0000);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        {e_stby, e_bank, e_ie} = '0;
        @(posedge mclk);
        #1;
        state_ok;
        chk(irq_accept, 1'h0);
        chk(ext_valid, 1'h0);
        $display("test mid reset done");
        wrap_up;
    end
endmodule : cpu_control_instructions_tb_top
